// [inc/iit_map.vh]
`ifndef IIT_MAP_VH
`define IIT_MAP_VH

// Instruction class codes presented by decode
`define IIT_CL_DATA_PROC 6'h00
`define IIT_CL_COUNT_ZEROS 6'h01
`define IIT_CL_BRANCH_PRED 6'h02
`define IIT_CL_LINK_EXCH_IMM 6'h03
`define IIT_CL_EXCH_REG 6'h04
`define IIT_CL_LOAD_PC 6'h05
`define IIT_CL_WORD_MUL 6'h06
`define IIT_CL_LONG_MUL 6'h07
`define IIT_CL_HALF_MUL 6'h08
`define IIT_CL_WORD_HALF_MUL 6'h09
`define IIT_CL_HALF_LONG_ACC 6'h0a
`define IIT_CL_ACC_MUL 6'h0b
`define IIT_CL_ACC_HALF_MUL 6'h0c
`define IIT_CL_ACC_PACKED_MUL 6'h0d
`define IIT_CL_ACC_WRITE 6'h0e
`define IIT_CL_ACC_READ 6'h0f
`define IIT_CL_SATURATING 6'h10
`define IIT_CL_STATUS_READ 6'h11
`define IIT_CL_STATUS_WRITE 6'h12
`define IIT_CL_LOAD_STORE 6'h13
`define IIT_CL_LOAD_DOUBLE 6'h14
`define IIT_CL_STORE_DOUBLE 6'h15
`define IIT_CL_LOAD_MULTIPLE 6'h16
`define IIT_CL_STORE_MULTIPLE 6'h17
`define IIT_CL_ATOMIC_SWAP 6'h18
`define IIT_CL_SYSCP_READ 6'h19
`define IIT_CL_SYSCP_WRITE 6'h1a
`define IIT_CL_DBGCP_READ 6'h1b
`define IIT_CL_DBGCP_WRITE 6'h1c
`define IIT_CL_DBGCP_LOAD 6'h1d
`define IIT_CL_DBGCP_STORE 6'h1e
`define IIT_CL_SOFT_INT 6'h1f

// Latency figures in core cycles, and the free register count for load multiple
`define IIT_LAT_ONE 6'h01
`define IIT_LAT_TWO 6'h02
`define IIT_LAT_THREE 6'h03
`define IIT_LAT_FOUR 6'h04
`define IIT_LAT_FIVE 6'h05
`define IIT_LAT_SIX 6'h06
`define IIT_LAT_SEVEN 6'h07
`define IIT_LAT_EIGHT 6'h08
`define IIT_LAT_TEN 6'h0a
`define IIT_MISPREDICT_PENALTY 6'h04
`define IIT_LOAD_MULTIPLE_FREE_REGS 6'h03

// Early termination field positions
`define IIT_ET_SHORT_LSB 15
`define IIT_ET_MID_LSB 27
`define IIT_ACC_ET_SHORT_LSB 16
`define IIT_ACC_ET_MID_LSB 28

`endif

// [verilog/iit_scoreboard.v]
`timescale 1ns/1ps
`include "iit_map.vh"

// Per-register countdown of cycles until a result is usable
module iit_scoreboard #(
	parameter NREG = 16,
	parameter LW = 6
) (
	input wire clk_sys,
	input wire rst_n,
	input wire [2:0] wr_en,
	input wire [11:0] wr_reg,
	input wire [3*LW-1:0] wr_lat,
	input wire [2:0] wr_ext,
	input wire [3:0] rd_reg_a,
	input wire rd_late_a,
	input wire [3:0] rd_reg_b,
	output wire busy_a,
	output wire busy_b
);
	wire [NREG-1:0] pend_all;
	wire [NREG-1:0] ext_all;

	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi = gi + 1) begin : g_ent
			reg [LW-1:0] cnt_r;
			reg ext_r;
			reg [LW-1:0] cnt_nxt;
			reg ext_nxt;
			integer k;
			// Largest pending write wins, so a slower producer is never masked
			always @* begin
				cnt_nxt = (cnt_r != {LW{1'b0}}) ? cnt_r - 1'b1 : {LW{1'b0}};
				ext_nxt = ext_r & (cnt_r != {LW{1'b0}});
				for (k = 0; k < 3; k = k + 1) begin
					if (wr_en[k] && ({28'h0000000, wr_reg[4*k +: 4]} == gi)) begin
						if (wr_lat[LW*k +: LW] - 1'b1 >= cnt_nxt) begin
							cnt_nxt = wr_lat[LW*k +: LW] - 1'b1;
						end
						ext_nxt = ext_nxt | wr_ext[k];
					end
				end
			end
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					cnt_r <= {LW{1'b0}};
					ext_r <= 1'b0;
				end else begin
					cnt_r <= cnt_nxt;
					ext_r <= ext_nxt;
				end
			end
			// Per-entry state gathered so each entry keeps a single driver
			assign pend_all[gi] = (cnt_r != {LW{1'b0}});
			assign ext_all[gi] = ext_r;
		end
	endgenerate

	// Late users need one cycle past the normal point
	assign busy_a = pend_all[rd_reg_a] | (rd_late_a & ext_all[rd_reg_a]);
	assign busy_b = pend_all[rd_reg_b];
endmodule

// [verilog/iit_issue_ctrl.v]
`timescale 1ns/1ps
`include "iit_map.vh"

module iit_issue_ctrl #(
	parameter LW = 6
) (
	input wire clk_sys,
	input wire rst_n,
	input wire instr_valid,
	input wire [5:0] instr_class,
	input wire compressed_long_branch_first,
	input wire branch_taken,
	input wire predict_ok,
	input wire writes_pc,
	input wire reg_shift_operand,
	input wire set_flags,
	input wire accumulating,
	input wire mode_update,
	input wire dest_is_r12,
	input wire pc_in_list,
	input wire [4:0] reg_count,
	input wire [31:0] multiplier_operand,
	input wire src_a_used,
	input wire [3:0] src_a_reg,
	input wire src_a_late_use,
	input wire src_b_used,
	input wire [3:0] src_b_reg,
	input wire low_result_word_used,
	input wire [3:0] low_result_word_reg,
	input wire high_result_word_used,
	input wire [3:0] high_result_word_reg,
	input wire base_writeback_used,
	input wire [3:0] base_reg,
	output wire instr_ready,
	output wire issue_pulse,
	output reg [LW-1:0] issue_latency_r,
	output reg [LW-1:0] low_result_latency_r,
	output reg [LW-1:0] high_result_latency_r,
	output reg [LW-1:0] throughput_r,
	output reg [1:0] early_term_class_r,
	output reg dep_stall_r
);
	localparam ET_SHORT = 2'd0;
	localparam ET_MID = 2'd1;
	localparam ET_FULL = 2'd2;

	reg [LW-1:0] issue_cnt_r;
	reg [LW-1:0] mul_cnt_r;
	reg [LW-1:0] lat_issue, lat_lo, lat_hi, lat_base, lat_tput;
	reg uses_mac, ext_ok;
	reg [5:0] eff_class;
	reg [1:0] et_word, et_acc;
	reg [LW-1:0] n_regs;
	wire busy_a, busy_b, dep_stall;

	always @* begin
		if (&multiplier_operand[31:`IIT_ET_SHORT_LSB] || ~|multiplier_operand[31:`IIT_ET_SHORT_LSB]) begin
			et_word = ET_SHORT;
		end else if (&multiplier_operand[31:`IIT_ET_MID_LSB] || ~|multiplier_operand[31:`IIT_ET_MID_LSB]) begin
			et_word = ET_MID;
		end else begin
			et_word = ET_FULL;
		end
		if (&multiplier_operand[31:`IIT_ACC_ET_SHORT_LSB] || ~|multiplier_operand[31:`IIT_ACC_ET_SHORT_LSB]) begin
			et_acc = ET_SHORT;
		end else if (&multiplier_operand[31:`IIT_ACC_ET_MID_LSB] || ~|multiplier_operand[31:`IIT_ACC_ET_MID_LSB]) begin
			et_acc = ET_MID;
		end else begin
			et_acc = ET_FULL;
		end
	end

	// Timing lookup per class; lat_tput of zero means no multiplier claim
	always @* begin
		n_regs = {1'b0, reg_count};
		// first half of long branch times as data op
		eff_class = compressed_long_branch_first ? `IIT_CL_DATA_PROC : instr_class;
		lat_issue = `IIT_LAT_ONE;
		lat_lo = `IIT_LAT_ONE;
		lat_hi = `IIT_LAT_ONE;
		lat_base = `IIT_LAT_ONE;
		lat_tput = {LW{1'b0}};
		uses_mac = 1'b0;
		ext_ok = 1'b0;
		case (eff_class)
			// data ops, register shift costs two
			`IIT_CL_DATA_PROC: begin
				lat_issue = reg_shift_operand ? `IIT_LAT_TWO : `IIT_LAT_ONE;
				lat_lo = lat_issue;
				ext_ok = 1'b1;
				if (writes_pc && branch_taken) begin
					lat_issue = lat_issue + `IIT_MISPREDICT_PENALTY;
				end
			end
			`IIT_CL_BRANCH_PRED: begin
				lat_issue = predict_ok ? `IIT_LAT_ONE : `IIT_LAT_ONE + `IIT_MISPREDICT_PENALTY;
			end
			`IIT_CL_LINK_EXCH_IMM: begin
				lat_issue = `IIT_LAT_FIVE;
			end
			`IIT_CL_EXCH_REG: begin
				lat_issue = branch_taken ? `IIT_LAT_FIVE : `IIT_LAT_ONE;
			end
			`IIT_CL_LOAD_PC: begin
				lat_issue = branch_taken ? `IIT_LAT_EIGHT : `IIT_LAT_TWO;
				lat_lo = `IIT_LAT_THREE;
			end
			`IIT_CL_WORD_MUL: begin
				uses_mac = 1'b1;
				ext_ok = 1'b1;
				lat_lo = `IIT_LAT_TWO + {4'h0, et_word};
				lat_tput = set_flags ? lat_lo : `IIT_LAT_ONE + {4'h0, et_word};
				lat_issue = set_flags ? lat_lo : `IIT_LAT_ONE;
			end
			// long multiply, high word one later unless set_flags, then same as low
			`IIT_CL_LONG_MUL: begin
				uses_mac = 1'b1;
				ext_ok = 1'b1;
				if (set_flags) begin
					lat_issue = `IIT_LAT_THREE + {4'h0, et_word};
					lat_lo = lat_issue;
					lat_hi = lat_issue;
					lat_tput = lat_issue;
				end else begin
					lat_issue = accumulating ? `IIT_LAT_TWO : `IIT_LAT_ONE;
					lat_lo = `IIT_LAT_TWO + {4'h0, et_word};
					lat_hi = `IIT_LAT_THREE + {4'h0, et_word};
					lat_tput = lat_lo;
				end
			end
			`IIT_CL_HALF_MUL: begin
				uses_mac = 1'b1;
				ext_ok = 1'b1;
				lat_lo = `IIT_LAT_TWO;
				lat_tput = `IIT_LAT_ONE;
			end
			`IIT_CL_WORD_HALF_MUL: begin
				uses_mac = 1'b1;
				ext_ok = 1'b1;
				lat_lo = `IIT_LAT_THREE;
				lat_tput = `IIT_LAT_TWO;
			end
			`IIT_CL_HALF_LONG_ACC: begin
				uses_mac = 1'b1;
				ext_ok = 1'b1;
				lat_issue = `IIT_LAT_TWO;
				lat_lo = `IIT_LAT_TWO;
				lat_hi = `IIT_LAT_THREE;
				lat_tput = `IIT_LAT_TWO;
			end
			`IIT_CL_ACC_MUL: begin
				uses_mac = 1'b1;
				lat_lo = `IIT_LAT_ONE + {4'h0, et_acc};
				lat_tput = lat_lo;
			end
			`IIT_CL_ACC_HALF_MUL: begin
				uses_mac = 1'b1;
				lat_tput = `IIT_LAT_ONE;
			end
			`IIT_CL_ACC_PACKED_MUL: begin
				uses_mac = 1'b1;
				lat_lo = `IIT_LAT_TWO;
				lat_tput = `IIT_LAT_TWO;
			end
			`IIT_CL_ACC_WRITE: begin
				uses_mac = 1'b1;
				lat_issue = `IIT_LAT_TWO;
				lat_lo = `IIT_LAT_TWO;
				lat_tput = `IIT_LAT_TWO;
			end
			`IIT_CL_ACC_READ: begin
				uses_mac = 1'b1;
				ext_ok = 1'b1;
				lat_lo = `IIT_LAT_TWO;
				lat_hi = `IIT_LAT_THREE;
				lat_tput = `IIT_LAT_TWO;
			end
			`IIT_CL_SATURATING, `IIT_CL_STATUS_READ: begin
				lat_lo = `IIT_LAT_TWO;
			end
			`IIT_CL_STATUS_WRITE: begin
				lat_issue = mode_update ? `IIT_LAT_SIX : `IIT_LAT_TWO;
			end
			`IIT_CL_LOAD_STORE: begin
				lat_lo = `IIT_LAT_THREE;
			end
			`IIT_CL_LOAD_DOUBLE: begin
				lat_issue = dest_is_r12 ? `IIT_LAT_TWO : `IIT_LAT_ONE;
				lat_lo = `IIT_LAT_THREE;
				lat_hi = `IIT_LAT_FOUR;
				lat_base = `IIT_LAT_TWO;
			end
			`IIT_CL_STORE_DOUBLE, `IIT_CL_SYSCP_WRITE: begin
				lat_issue = `IIT_LAT_TWO;
			end
			// multiple transfers; covers PC in list
			`IIT_CL_LOAD_MULTIPLE: begin
				lat_lo = `IIT_LAT_THREE;
				if (!pc_in_list) begin
					lat_issue = `IIT_LAT_TWO + n_regs;
				end else if (!branch_taken) begin
					lat_issue = `IIT_LAT_THREE + n_regs;
				end else if (n_regs > `IIT_LOAD_MULTIPLE_FREE_REGS) begin
					lat_issue = `IIT_LAT_TEN + n_regs - `IIT_LOAD_MULTIPLE_FREE_REGS;
				end else begin
					lat_issue = `IIT_LAT_TEN;
				end
			end
			`IIT_CL_STORE_MULTIPLE: begin
				lat_issue = `IIT_LAT_TWO + n_regs;
			end
			`IIT_CL_ATOMIC_SWAP: begin
				lat_issue = `IIT_LAT_FIVE;
				lat_lo = `IIT_LAT_FIVE;
			end
			`IIT_CL_SYSCP_READ: begin
				lat_issue = `IIT_LAT_FOUR;
				lat_lo = `IIT_LAT_FOUR;
			end
			`IIT_CL_DBGCP_READ: begin
				lat_issue = `IIT_LAT_SEVEN;
				lat_lo = `IIT_LAT_SEVEN;
			end
			`IIT_CL_DBGCP_WRITE, `IIT_CL_DBGCP_STORE: begin
				lat_issue = `IIT_LAT_SEVEN;
			end
			`IIT_CL_DBGCP_LOAD: begin
				lat_issue = `IIT_LAT_TEN;
			end
			// handler entry no sooner than six
			`IIT_CL_SOFT_INT: begin
				lat_issue = `IIT_LAT_SIX;
			end
			// count zeros lands here, one cycle
			default: begin
				lat_issue = `IIT_LAT_ONE;
			end
		endcase
	end

	iit_scoreboard #(.NREG(16), .LW(LW)) u_sb (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.wr_en({base_writeback_used, high_result_word_used, low_result_word_used} & {3{issue_pulse}}),
		.wr_reg({base_reg, high_result_word_reg, low_result_word_reg}),
		.wr_lat({lat_base, lat_hi, lat_lo}),
		.wr_ext({1'b0, ext_ok, ext_ok}),
		.rd_reg_a(src_a_reg),
		.rd_late_a(src_a_late_use),
		.rd_reg_b(src_b_reg),
		.busy_a(busy_a),
		.busy_b(busy_b)
	);

	assign dep_stall = (src_a_used & busy_a) | (src_b_used & busy_b);

	// Issue gate: spacing, multiplier throughput, then data hazards
	assign instr_ready = (issue_cnt_r == {LW{1'b0}}) & ~(uses_mac & (mul_cnt_r != {LW{1'b0}})) & ~dep_stall;
	assign issue_pulse = instr_valid & instr_ready;

	// Countdowns restart on issue; cycle of issue counts as cycle 0
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			issue_cnt_r <= {LW{1'b0}};
			mul_cnt_r <= {LW{1'b0}};
			issue_latency_r <= {LW{1'b0}};
			low_result_latency_r <= {LW{1'b0}};
			high_result_latency_r <= {LW{1'b0}};
			throughput_r <= {LW{1'b0}};
			early_term_class_r <= 2'd0;
			dep_stall_r <= 1'b0;
		end else begin
			dep_stall_r <= instr_valid & dep_stall;
			if (issue_pulse) begin
				issue_cnt_r <= lat_issue - 1'b1;
				issue_latency_r <= lat_issue;
				low_result_latency_r <= lat_lo;
				high_result_latency_r <= lat_hi;
				throughput_r <= lat_tput;
				early_term_class_r <= (eff_class == `IIT_CL_ACC_MUL) ? et_acc : et_word;
			end else if (issue_cnt_r != {LW{1'b0}}) begin
				issue_cnt_r <= issue_cnt_r - 1'b1;
			end
			// Multiplier resource is held for its throughput time
			if (issue_pulse && uses_mac) begin
				mul_cnt_r <= lat_tput - 1'b1;
			end else if (mul_cnt_r != {LW{1'b0}}) begin
				mul_cnt_r <= mul_cnt_r - 1'b1;
			end
		end
	end
endmodule

// [bench/iit_checker_asserts.sv]
`timescale 1ns/1ps
`include "iit_map.vh"

// Issue-port timing checks; latency outputs are seen one cycle after issue
module iit_checker (
	input wire clk_sys,
	input wire rst_n,
	input wire instr_valid,
	input wire [5:0] instr_class,
	input wire branch_taken,
	input wire reg_shift_operand,
	input wire set_flags,
	input wire [31:0] multiplier_operand,
	input wire instr_ready,
	input wire issue_pulse,
	input wire [5:0] issue_latency_r,
	input wire [5:0] low_result_latency_r,
	input wire [5:0] throughput_r,
	input wire [1:0] early_term_class_r
);
	reg [5:0] since_r;
	wire wmul;
	wire et_short;
	wire et_full;
	wire any_mul;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Saturates so that long idle spans never wrap
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			since_r <= 6'h3f;
		else if (issue_pulse)
			since_r <= 6'h01;
		else if (since_r != 6'h3f)
			since_r <= since_r + 6'h01;
	end
	// Operand classes and issue kinds
	assign wmul = issue_pulse && instr_class == `IIT_CL_WORD_MUL && !set_flags;
	assign et_short = &multiplier_operand[31:15] || ~|multiplier_operand[31:15];
	assign et_full = !(&multiplier_operand[31:27] || ~|multiplier_operand[31:27]);
	assign any_mul = instr_class >= `IIT_CL_WORD_MUL && instr_class <= `IIT_CL_ACC_READ;
	a_issue_spacing: assert property (issue_pulse |-> since_r >= issue_latency_r)
		else $error("issue before previous latency elapsed");
	a_data_plain: assert property (issue_pulse && instr_class == `IIT_CL_DATA_PROC && !reg_shift_operand
		&& !branch_taken |=> issue_latency_r == 6'h01 && low_result_latency_r == 6'h01) else $error("plain data timing");
	a_data_shift: assert property (issue_pulse && instr_class == `IIT_CL_DATA_PROC && reg_shift_operand
		&& !branch_taken |=> issue_latency_r == 6'h02 && low_result_latency_r == 6'h02) else $error("shifted data timing");
	a_exch_taken: assert property (issue_pulse && instr_class == `IIT_CL_EXCH_REG && branch_taken
		|=> issue_latency_r == 6'h05) else $error("taken exchange latency");
	a_mul_short: assert property (wmul && et_short
		|=> early_term_class_r == 2'h0 && throughput_r == 6'h01 && low_result_latency_r == 6'h02)
		else $error("short multiply timing");
	a_mul_full_gap: assert property (wmul && et_full |=> !(issue_pulse && any_mul) [*2])
		else $error("multiply inside throughput window");
	a_et_full: assert property (wmul && et_full |=> early_term_class_r == 2'h2)
		else $error("full termination class missing");
	a_sat_result: assert property (issue_pulse && instr_class == `IIT_CL_SATURATING
		|=> issue_latency_r == 6'h01 && low_result_latency_r == 6'h02) else $error("saturating timing");
	// Main scenarios reached
	c_branch: cover property (issue_pulse && instr_class == `IIT_CL_BRANCH_PRED);
	c_refused: cover property (instr_valid && !instr_ready);
	c_full_mul: cover property (wmul && et_full);
endmodule

bind iit_issue_ctrl iit_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid),
	.instr_class(instr_class), .branch_taken(branch_taken), .reg_shift_operand(reg_shift_operand),
	.set_flags(set_flags), .multiplier_operand(multiplier_operand), .instr_ready(instr_ready),
	.issue_pulse(issue_pulse), .issue_latency_r(issue_latency_r), .low_result_latency_r(low_result_latency_r),
	.throughput_r(throughput_r), .early_term_class_r(early_term_class_r));

// [bench/test_instruction_issue_timing.sv]
`timescale 1ns/1ps
`include "iit_map.vh"

module test_instruction_issue_timing;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic instr_valid = 1'b0;
	logic [5:0] instr_class = 6'h00;
	logic [14:0] fl = 15'h0;
	logic [31:0] mop = 32'h0;
	logic [25:0] dp = 26'h0;
	logic [5:0] nc = `IIT_CL_DATA_PROC;
	logic [25:0] nd = 26'h0;
	wire issue_pulse;
	wire rdy;
	wire [5:0] hi_lat;
	wire stall_seen;
	int cyc = 0;
	int t_iss = 0;
	int error_cnt = 0;
	int n_tests = 0;

	// Side flags and register fields travel packed in fl and dp
	iit_issue_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid), .instr_class(instr_class),
		.compressed_long_branch_first(fl[0]), .branch_taken(fl[1]), .predict_ok(fl[2]), .writes_pc(fl[3]),
		.reg_shift_operand(fl[4]), .set_flags(fl[5]), .accumulating(fl[6]), .mode_update(fl[7]),
		.dest_is_r12(fl[8]), .pc_in_list(fl[9]), .reg_count(fl[14:10]), .multiplier_operand(mop),
		.src_a_used(dp[25]), .src_a_reg(dp[24:21]), .src_a_late_use(dp[20]), .src_b_used(dp[19]),
		.src_b_reg(dp[18:15]), .low_result_word_used(dp[14]), .low_result_word_reg(dp[13:10]),
		.high_result_word_used(dp[9]), .high_result_word_reg(dp[8:5]), .base_writeback_used(dp[4]),
		.base_reg(dp[3:0]), .instr_ready(rdy), .issue_pulse(issue_pulse), .issue_latency_r(),
		.low_result_latency_r(), .high_result_latency_r(hi_lat), .throughput_r(), .early_term_class_r(),
		.dep_stall_r(stall_seen));

	// 50 ns period and a cycle count for gap measurement
	initial begin
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc <= cyc + 1;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Hold one instruction until its issue edge; pulse sampled at falling edge to avoid races
	task automatic iss(input logic [5:0] c, input logic [14:0] f, input logic [31:0] o, input logic [25:0] d);
		int k;
		k = 0;
		instr_class = c;
		fl = f;
		mop = o;
		dp = d;
		instr_valid = 1'b1;
		@(negedge clk_sys);
		while (issue_pulse !== 1'b1 && k < 40) begin
			@(negedge clk_sys);
			k++;
		end
		// A refusal that never ends is a failure of its own
		if (k >= 40)
			error_cnt++;
		@(posedge clk_sys);
		#1;
		t_iss = cyc;
	endtask

	// Producer then queued follower; the gap between issues is compared
	task automatic g(input logic [5:0] c, input logic [14:0] f, input logic [31:0] o, input logic [25:0] d,
		input int eg);
		int t0;
		iss(c, f, o, d);
		t0 = t_iss;
		iss(nc, 15'h0, 32'h0, nd);
		chk(t_iss - t0, eg);
		instr_valid = 1'b0;
		repeat (30) @(posedge clk_sys);
		#1;
		nc = `IIT_CL_DATA_PROC;
		nd = 26'h0;
	endtask

	task automatic t_branch;
		g(`IIT_CL_BRANCH_PRED, 15'h004, 32'h0, 26'h0, 1);
		g(`IIT_CL_BRANCH_PRED, 15'h000, 32'h0, 26'h0, 5);
		g(`IIT_CL_EXCH_REG, 15'h002, 32'h0, 26'h0, 5);
		g(`IIT_CL_BRANCH_PRED, 15'h001, 32'h0, 26'h0, 1);
	endtask

	// Data ops, pc writers, a late-use consumer, and result hazards after loads and saturating ops
	task automatic t_data;
		g(`IIT_CL_DATA_PROC, 15'h010, 32'h0, 26'h0, 2);
		g(`IIT_CL_DATA_PROC, 15'h01a, 32'h0, 26'h0, 6);
		nd = 26'h2700000;
		g(`IIT_CL_DATA_PROC, 15'h0, 32'h0, 26'h4c00, 2);
		nd = 26'h2600000;
		g(`IIT_CL_LOAD_STORE, 15'h0, 32'h0, 26'h4c00, 3);
		nd = 26'h2800000;
		g(`IIT_CL_LOAD_DOUBLE, 15'h100, 32'h0, 26'h4e80, 4);
		nd = 26'h2600000;
		g(`IIT_CL_SATURATING, 15'h0, 32'h0, 26'h4c00, 2);
	endtask

	// Multiplier classes; follower is a short word multiply where throughput matters
	task automatic t_mul;
		nc = `IIT_CL_WORD_MUL;
		g(`IIT_CL_WORD_MUL, 15'h0, 32'h00123456, 26'h0, 2);
		nc = `IIT_CL_WORD_MUL;
		g(`IIT_CL_WORD_MUL, 15'h0, 32'h12345678, 26'h0, 3);
		g(`IIT_CL_WORD_MUL, 15'h020, 32'h12345678, 26'h0, 4);
		g(`IIT_CL_LONG_MUL, 15'h040, 32'h00123456, 26'h0, 2);
		nd = 26'h2800000;
		g(`IIT_CL_LONG_MUL, 15'h0, 32'h12345678, 26'h4e80, 5);
		nc = `IIT_CL_WORD_MUL;
		g(`IIT_CL_WORD_HALF_MUL, 15'h0, 32'h0, 26'h0, 2);
		nc = `IIT_CL_WORD_MUL;
		g(`IIT_CL_ACC_MUL, 15'h0, 32'h0fff0000, 26'h0, 2);
		nd = 26'h2800000;
		g(`IIT_CL_ACC_READ, 15'h0, 32'h0, 26'h4e80, 3);
	endtask

	// Memory, status, coprocessor and exception classes
	task automatic t_mem;
		g(`IIT_CL_LOAD_MULTIPLE, 15'h4202, 32'h0, 26'h0, 23);
		g(`IIT_CL_LOAD_PC, 15'h002, 32'h0, 26'h0, 8);
		g(`IIT_CL_LOAD_MULTIPLE, 15'h1400, 32'h0, 26'h0, 7);
		g(`IIT_CL_STATUS_WRITE, 15'h080, 32'h0, 26'h0, 6);
		nd = 26'h2600000;
		g(`IIT_CL_ATOMIC_SWAP, 15'h0, 32'h0, 26'h4c00, 5);
		nd = 26'h2600000;
		g(`IIT_CL_SYSCP_READ, 15'h0, 32'h0, 26'h4c00, 4);
		g(`IIT_CL_DBGCP_LOAD, 15'h0, 32'h0, 26'h0, 10);
		g(`IIT_CL_SOFT_INT, 15'h0, 32'h0, 26'h0, 6);
	endtask

	// Second-word latency, refusal and stall flag on a source-b hazard
	task automatic t_outs;
		int t0;
		iss(`IIT_CL_LONG_MUL, 15'h0, 32'h12345678, 26'h4e80);
		t0 = t_iss;
		chk(hi_lat, 6'h05);
		dp = 26'h0a0000;
		instr_class = `IIT_CL_DATA_PROC;
		@(posedge clk_sys);
		#1;
		chk(rdy, 1'b0);
		chk(stall_seen, 1'b1);
		iss(`IIT_CL_DATA_PROC, 15'h0, 32'h0, 26'h0a0000);
		chk(t_iss - t0, 5);
		chk(stall_seen, 1'b0);
		instr_valid = 1'b0;
		repeat (30) @(posedge clk_sys);
		#1;
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Reset for ten cycles, then the scenarios
	initial begin
		repeat (10) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		@(posedge clk_sys);
		#1;
		t_branch;
		t_data;
		t_mul;
		t_mem;
		t_outs;
		report_and_stop;
	end

	// Run needs about 1000 cycles; cut a hang well beyond that
	initial begin
		#500000;
		error_cnt++;
		report_and_stop;
	end
endmodule
